/* verilog/frc_timer.sv */
// Free-running counter with two edge-capture channels
`timescale 1ns/100ps

module frc_timer
  import frc_pkg::*;
#(
  parameter int DIV = TIMER_DIV
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic capture_input_a_in,
  input wire logic capture_input_b_in,
  output logic tick_evt_out,
  output logic overflow_evt_out,
  output logic [3:0] capture_irq_req_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  frc_req_t req; // Bundled register request
  logic [$clog2(DIV+1)-1:0] div_reg; // Timer-rate divider
  logic count_en; // One-cycle timer-rate enable
  logic [15:0] count_reg; // Free-running counter
  logic [7:0] low_buf_reg; // Pending low byte for a load
  logic [7:0] high_snap_reg; // High byte held at low read
  logic [7:0] rdata_reg; // Read data, one cycle after strobe
  logic [7:0] rdata_next; // Read mux output
  logic tick_reg; // Tick event pulse
  logic overflow_reg; // Overflow event pulse
  frc_cfg_t cfg_reg; // Timer configuration
  logic [3:0] irq_en_reg; // Capture interrupt enables
  logic [1:0] sync1_reg; // First synchroniser stage
  logic [1:0] sync2_reg; // Second synchroniser stage
  logic [1:0] prev_reg; // Previous synchronised level
  logic [1:0] rise; // Rising edge per pin
  logic [1:0] fall; // Falling edge per pin
  logic [7:0] window; // Prescaled counter byte
  logic [3:0] ev; // Edge per capture source
  logic [3:0] rd_hit; // Read of each capture register
  logic [3:0] load; // Capture register loads this cycle
  logic [3:0] stat_vec; // Packed status flags
  logic [7:0] cap_reg [4]; // a rise, a fall, b rise, b fall
  logic held_reg [4]; // First edge held per source
  logic status_reg [4]; // Capture status flags

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // ----------------------------------------------------------------
  // Timer-rate divider
  // ----------------------------------------------------------------
  // own rate enable
  // Timer logic advances only on its own enable, so bus traffic of
  // any pattern never stretches or skips a count.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      div_reg <= '0;
    end else if (32'(div_reg) == DIV - 1) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign count_en = (32'(div_reg) == DIV - 1);

  // ----------------------------------------------------------------
  // Free-running counter and load path
  // ----------------------------------------------------------------
  // counter increment
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      count_reg <= RESET_COUNT;
    end else if (req.wr && req.addr == FREE_COUNT_HIGH) begin
      // Whole value lands at once; low byte came from earlier write
      count_reg <= {req.wdata, low_buf_reg};
    end else if (count_en) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // low byte buffered
  // Low byte waits here until the high-byte write commits both
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      low_buf_reg <= RESET_BYTE;
    end else if (req.wr && req.addr == FREE_COUNT_LOW) begin
      low_buf_reg <= req.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      high_snap_reg <= RESET_BYTE;
    end else if (req.rd && req.addr == FREE_COUNT_LOW) begin
      high_snap_reg <= count_reg[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Tick and overflow events
  // ----------------------------------------------------------------
  // periodic tick
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tick_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      tick_reg <= count_en && ((count_reg & TICK_MASK) == TICK_MASK);
      overflow_reg <= count_en && (count_reg == OVERFLOW_LAST);
    end
  end

  assign tick_evt_out = tick_reg;
  assign overflow_evt_out = overflow_reg;

  // ----------------------------------------------------------------
  // Configuration and enable registers
  // ----------------------------------------------------------------
  // enable bits
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_reg <= '0;
      irq_en_reg <= '0;
    end else if (req.wr) begin
      if (req.addr == TIMER_CONFIG) begin
        cfg_reg <= frc_cfg_t'(req.wdata[CFG_HOLD_BIT:CFG_WIDE_BIT]);
      end
      if (req.addr == CAPTURE_IRQ_ENABLE) begin
        irq_en_reg <= req.wdata[IRQ_FIELD_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // two-stage synchroniser
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      sync1_reg <= {capture_input_b_in, capture_input_a_in};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  assign window = 8'(count_reg >> cfg_reg.prescale);

  // edge sources
  // In wide mode channel b pin is ignored; pin a drives all four
  assign ev[0] = rise[0];
  assign ev[1] = fall[0];
  assign ev[2] = cfg_reg.wide_capture_enable ? rise[0] : rise[1];
  assign ev[3] = cfg_reg.wide_capture_enable ? fall[0] : fall[1];

  assign rd_hit[0] = req.rd && req.addr == CAPTURE_A_RISE;
  assign rd_hit[1] = req.rd && req.addr == CAPTURE_A_FALL;
  assign rd_hit[2] = req.rd && req.addr == CAPTURE_B_RISE;
  assign rd_hit[3] = req.rd && req.addr == CAPTURE_B_FALL;

  // ----------------------------------------------------------------
  // Capture sources
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_cap
    // Value chosen for this source
    logic [7:0] value;
    assign value = !cfg_reg.wide_capture_enable ? window :
                   (i < 2) ? count_reg[7:0] : count_reg[15:8];

    // blocked while held
    // A read in the same cycle frees the slot for the new edge
    assign load[i] = ev[i] &&
                     (!cfg_reg.hold_first || !held_reg[i] || rd_hit[i]);

    // Capture register
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        cap_reg[i] <= RESET_BYTE;
      end else if (load[i]) begin
        cap_reg[i] <= value;
      end
    end

    // first edge tracking
    // Load wins over the releasing read
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        held_reg[i] <= 1'b0;
      end else if (load[i]) begin
        held_reg[i] <= cfg_reg.hold_first;
      end else if (rd_hit[i]) begin
        held_reg[i] <= 1'b0;
      end
    end

    // sticky status flag
    // A new capture beats a write-one clear in the same cycle
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        status_reg[i] <= 1'b0;
      end else if (load[i]) begin
        status_reg[i] <= 1'b1;
      end else if (req.wr && req.addr == CAPTURE_IRQ_STATUS &&
                   req.wdata[i]) begin
        status_reg[i] <= 1'b0;
      end
    end

    assign stat_vec[i] = status_reg[i];
  end

  assign capture_irq_req_out = stat_vec & irq_en_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    case (req.addr)
      FREE_COUNT_LOW: rdata_next = count_reg[7:0];
      FREE_COUNT_HIGH: rdata_next = high_snap_reg;
      CAPTURE_A_RISE: rdata_next = cap_reg[0];
      CAPTURE_A_FALL: rdata_next = cap_reg[1];
      CAPTURE_B_RISE: rdata_next = cap_reg[2];
      CAPTURE_B_FALL: rdata_next = cap_reg[3];
      TIMER_CONFIG: rdata_next = {cfg_reg, 3'h0};
      CAPTURE_IRQ_ENABLE: rdata_next = {4'h0, irq_en_reg};
      CAPTURE_IRQ_STATUS: rdata_next = {4'h0, stat_vec};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands for one cycle only
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_reg <= RESET_BYTE;
    end else if (req.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RESET_BYTE;
    end
  end

  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_count_step: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    count_en && !(req.wr && req.addr == FREE_COUNT_HIGH)
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("Counter did not step on timer enable");

  a_count_still: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !count_en && !(req.wr && req.addr == FREE_COUNT_HIGH)
    |=> $stable(count_reg))
    else $error("Counter moved without timer enable");

  a_high_load: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    req.wr && req.addr == FREE_COUNT_LOW ##1
    req.wr && req.addr == FREE_COUNT_HIGH
    |=> count_reg == {$past(wdata_in), $past(wdata_in, 2)})
    else $error("Counter load did not take both bytes");

  a_snap_pair: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    req.rd && req.addr == FREE_COUNT_LOW
    |=> rdata_out == $past(count_reg[7:0]) &&
        high_snap_reg == $past(count_reg[15:8]))
    else $error("Low read snapshot wrong");

  a_tick_pulse: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    count_en && count_reg[11:0] == 12'hFFF |=> tick_evt_out)
    else $error("Tick missing at 12-bit wrap");

  a_overflow_pulse: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    overflow_evt_out |-> $past(count_reg) == 16'hFFFF && $past(count_en))
    else $error("Overflow pulse without wrap");

  a_hold_block: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    cfg_reg.hold_first && held_reg[0] && !rd_hit[0]
    |=> $stable(cap_reg[0]))
    else $error("Held capture was overwritten");

  a_wide_high: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    cfg_reg.wide_capture_enable && rise[0] && load[0] && load[2]
    |=> cap_reg[2] == $past(count_reg[15:8]) &&
        cap_reg[0] == $past(count_reg[7:0]))
    else $error("Wide capture bytes wrong");

  a_status_set: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    load[1] |=> stat_vec[1] ##1 (stat_vec[1] || $past(req.wr)))
    else $error("Status flag not set by capture");

  a_irq_gate: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    load[0] && irq_en_reg[0] &&
    !(req.wr && req.addr == CAPTURE_IRQ_ENABLE)
    |=> capture_irq_req_out[0])
    else $error("Enabled capture raised no request");

  a_status_clear: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    req.wr && req.addr == CAPTURE_IRQ_STATUS && req.wdata[0] && !load[0]
    |=> !stat_vec[0])
    else $error("Status flag not cleared by write one");

  a_sync_delay: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    rise[0] |-> $past(capture_input_a_in, 2) &&
                !$past(capture_input_a_in, 3))
    else $error("Edge seen without synchronised pin change");

  a_hold_release: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    cfg_reg.hold_first && held_reg[0] && rd_hit[0] && !ev[0]
    |=> !held_reg[0])
    else $error("Read did not release the held capture");

  a_narrow_window: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    !cfg_reg.wide_capture_enable && load[2]
    |=> cap_reg[2] == $past(count_reg[cfg_reg.prescale +: 8]))
    else $error("Capture byte not at prescale window");

endmodule : frc_timer

/* verilog/frc_pkg.sv */
// Package for the free-running timer with edge capture
package frc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FREE_COUNT_LOW = 8'h20;
  localparam logic [7:0] FREE_COUNT_HIGH = 8'h21;
  localparam logic [7:0] CAPTURE_A_RISE = 8'h22;
  localparam logic [7:0] CAPTURE_B_RISE = 8'h23;
  localparam logic [7:0] CAPTURE_A_FALL = 8'h24;
  localparam logic [7:0] CAPTURE_B_FALL = 8'h25;
  localparam logic [7:0] TIMER_CONFIG = 8'h2A;
  localparam logic [7:0] CAPTURE_IRQ_ENABLE = 8'h2B;
  localparam logic [7:0] CAPTURE_IRQ_STATUS = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_HOLD_BIT = 7;
  localparam int CFG_PRESCALE_LSB = 4;
  localparam int CFG_WIDE_BIT = 3;
  localparam int IRQ_FIELD_W = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 40_000_000;
  localparam int TIMER_HZ = 4_000_000;
  // Clock cycles per timer count (rounded down, at least one)
  localparam int TIMER_DIV = (CLOCK_HZ / TIMER_HZ < 1) ? 1 :
                             CLOCK_HZ / TIMER_HZ;
  localparam int TICK_PERIOD_US = 1024;
  localparam int OVERFLOW_PERIOD_US = 16384;
  // Timer counts per periodic tick
  localparam int TICK_COUNTS = TICK_PERIOD_US * (TIMER_HZ / 1_000_000);
  localparam logic [15:0] TICK_MASK = 16'(TICK_COUNTS - 1);
  // Timer counts per overflow
  localparam int OVERFLOW_COUNTS =
    OVERFLOW_PERIOD_US * (TIMER_HZ / 1_000_000);
  localparam logic [15:0] OVERFLOW_LAST = 16'(OVERFLOW_COUNTS - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Timer configuration fields
  typedef struct packed {
    logic hold_first;
    logic [2:0] prescale;
    logic wide_capture_enable;
  } frc_cfg_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } frc_req_t;

endpackage : frc_pkg

/* test/frc_pins.sv */
// Model of the outside source that drives the two capture pins
`timescale 1ns/100ps

module frc_pins (
  input wire logic clock_in,
  input wire logic [1:0] level_req_in,
  output logic capture_input_a_out = 1'b0,
  output logic capture_input_b_out = 1'b0
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Pins move only on a clock edge, so every level lasts a full cycle
  always_ff @(posedge clock_in) begin
    capture_input_a_out <= level_req_in[0];
    capture_input_b_out <= level_req_in[1];
  end
endmodule : frc_pins

/* test/free_running_timer_capture_tb.sv */
// Self-checking bench for the free-running timer with edge capture
`timescale 1ns/100ps

module free_running_timer_capture_tb
  import frc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Slow count keeps a loaded value steady while edges are captured
  localparam int SIM_DIV = 64;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  frc_req_t req = '0; // Register port request
  logic [7:0] rdata_out;
  logic [1:0] pin_req = 2'b00; // Requested pin levels, bit 0 is pin a
  logic pin_a; // Capture pin a
  logic pin_b; // Capture pin b
  logic tick_evt_out;
  logic overflow_evt_out;
  logic [3:0] capture_irq_req_out;
  int n_errors = 0;
  int compares = 0;
  logic [15:0] v; // Value loaded into the counter

  always #12.5 clock_in = ~clock_in;

  frc_timer #(.DIV(SIM_DIV)) dut (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .addr_in(req.addr),
    .wdata_in(req.wdata),
    .wr_in(req.wr),
    .rd_in(req.rd),
    .rdata_out(rdata_out),
    .capture_input_a_in(pin_a),
    .capture_input_b_in(pin_b),
    .tick_evt_out(tick_evt_out),
    .overflow_evt_out(overflow_evt_out),
    .capture_irq_req_out(capture_irq_req_out)
  );

  frc_pins pins (
    .clock_in(clock_in),
    .level_req_in(pin_req),
    .capture_input_a_out(pin_a),
    .capture_input_b_out(pin_b)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run
  task automatic final_report(input bit timed_out);
    if (timed_out) begin
      n_errors++;
    end
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Compares one value with its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    req.rd <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_chk

  // Counter load, low byte first, strobes back to back
  task automatic load(input logic [15:0] val);
    @(posedge clock_in);
    req <= '{addr: FREE_COUNT_LOW, wdata: val[7:0], wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req <= '{addr: FREE_COUNT_HIGH, wdata: val[15:8], wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask : load

  // Waits until the counter just stepped, leaving a full step of margin
  task automatic sync_cnt;
    logic [7:0] first;
    logic [7:0] now;
    rd(FREE_COUNT_LOW, first);
    now = first;
    for (int i = 0; i < 100 && now === first; i++) begin
      rd(FREE_COUNT_LOW, now);
    end
    if (now === first) begin
      final_report(1'b1);
    end
  endtask : sync_cnt

  // Sets pin levels and lets the capture path settle
  task automatic set_pins(input logic [1:0] lvl);
    @(posedge clock_in);
    pin_req <= lvl;
    repeat (6) @(posedge clock_in);
  endtask : set_pins

  // Waits a bounded time for the tick or overflow pulse
  task automatic wait_evt(input bit ovf);
    int i;
    i = 0;
    while (i < 300 && (ovf ? overflow_evt_out : tick_evt_out) !== 1'b1) begin
      @(posedge clock_in);
      #1;
      i++;
    end
    if (i == 300) begin
      final_report(1'b1);
    end
  endtask : wait_evt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    // Reset values, unmapped offset reads zero
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(FREE_COUNT_LOW + i), RESET_BYTE);
    end
    rd_chk(TIMER_CONFIG, RESET_BYTE);
    rd_chk(CAPTURE_IRQ_ENABLE, RESET_BYTE);
    rd_chk(CAPTURE_IRQ_STATUS, RESET_BYTE);
    rd_chk(8'h30, 8'h00);
    wr(TIMER_CONFIG, 8'hFF);
    rd_chk(TIMER_CONFIG, 8'hF8);
    wr(CAPTURE_IRQ_ENABLE, 8'hFF);
    rd_chk(CAPTURE_IRQ_ENABLE, 8'h0F);
    $display("test registers done");
    // Snapshot taken at the low read, high byte held
    sync_cnt;
    load(16'h12FF);
    rd_chk(FREE_COUNT_LOW, 8'hFF);
    repeat (100) @(posedge clock_in);
    rd_chk(FREE_COUNT_HIGH, 8'h12);
    rd_chk(FREE_COUNT_LOW, 8'h00);
    rd_chk(FREE_COUNT_HIGH, 8'h13);
    $display("test snapshot done");
    // Tick and overflow events
    load(TICK_MASK - 16'h0001);
    wait_evt(1'b0);
    rd_chk(FREE_COUNT_LOW, 8'h00);
    rd_chk(FREE_COUNT_HIGH, 8'(16'(TICK_MASK + 1) >> 8));
    load(16'hFFFE);
    wait_evt(1'b1);
    rd_chk(FREE_COUNT_LOW, 8'h00);
    rd_chk(FREE_COUNT_HIGH, 8'h00);
    $display("test events done");
    // Every prescale code on both channels, both edge kinds
    for (int n = 0; n < 8; n++) begin
      v = 16'hA5C3 ^ 16'(n * 16'h1357);
      wr(TIMER_CONFIG, 8'(n << CFG_PRESCALE_LSB));
      sync_cnt;
      load(v);
      set_pins(2'b11);
      rd_chk(CAPTURE_A_RISE, 8'(v >> n));
      rd_chk(CAPTURE_B_RISE, 8'(v >> n));
      set_pins(2'b00);
      rd_chk(CAPTURE_A_FALL, 8'(v >> n));
      rd_chk(CAPTURE_B_FALL, 8'(v >> n));
    end
    rd_chk(CAPTURE_IRQ_STATUS, 8'h0F);
    wr(CAPTURE_IRQ_ENABLE, 8'h05);
    #1 check(8'(capture_irq_req_out), 8'h05);
    wr(CAPTURE_IRQ_STATUS, 8'h03);
    #1 check(8'(capture_irq_req_out), 8'h04);
    rd_chk(CAPTURE_IRQ_STATUS, 8'h0C);
    $display("test prescale done");
    // Wide capture: pin b ignored, channel b holds the high byte
    wr(TIMER_CONFIG, 8'h08);
    wr(CAPTURE_IRQ_STATUS, 8'h0F);
    sync_cnt;
    load(16'h5A30);
    set_pins(2'b10);
    rd_chk(CAPTURE_IRQ_STATUS, 8'h00);
    set_pins(2'b11);
    rd_chk(CAPTURE_A_RISE, 8'h30);
    rd_chk(CAPTURE_B_RISE, 8'h5A);
    set_pins(2'b00);
    rd_chk(CAPTURE_A_FALL, 8'h30);
    rd_chk(CAPTURE_B_FALL, 8'h5A);
    $display("test wide done");
    // Without hold the latest edge wins, no read in between
    wr(TIMER_CONFIG, 8'h00);
    sync_cnt;
    load(16'h0044);
    set_pins(2'b01);
    set_pins(2'b00);
    load(16'h0055);
    set_pins(2'b01);
    set_pins(2'b00);
    rd_chk(CAPTURE_A_RISE, 8'h55);
    $display("test overwrite done");
    // First-edge hold, released by a read
    wr(TIMER_CONFIG, 8'h80);
    sync_cnt;
    load(16'h0011);
    set_pins(2'b01);
    set_pins(2'b00);
    sync_cnt;
    load(16'h0022);
    set_pins(2'b01);
    rd_chk(CAPTURE_A_RISE, 8'h11);
    set_pins(2'b00);
    rd_chk(CAPTURE_A_FALL, 8'h11);
    set_pins(2'b01);
    rd_chk(CAPTURE_A_RISE, 8'h22);
    $display("test hold done");
    final_report(1'b0);
  end
endmodule : free_running_timer_capture_tb
